// ==== logic/ssc_port.sv ====
// Serial port control, data window, FIFOs and shift engine
//
// Behaviour
// RULE_01: Slave with output disable set never enables the transmit pin driver.
// RULE_02: Output disable is ignored in master mode; master always drives transmit. The code drives it only while the port is enabled.
// RULE_03: Software changes master/slave select only while port is disabled.
// RULE_04: Select bit 0 makes the port master, 1 makes it slave.
// RULE_05: Enable bit starts serial operation; cleared enable means no transfers.
// RULE_06: Software clears enable before reprogramming any control register.
// RULE_07: Loopback routes transmit shifter output into receive shifter input.
// RULE_08: Data register is 16 bits at offset 0x008; bits 31:16 reserved.
// RULE_09: Reading data returns receive FIFO head and removes it.
// RULE_10: Writing data stores the value into the transmit FIFO.
// RULE_11: Receive logic extracts each frame's word into the receive FIFO.
// RULE_12: Transmit logic loads FIFO words one at a time and shifts them out.
// RULE_13: Words under 16 bits are right-justified; unused upper bits ignored.
// RULE_14: Received words under 16 bits are right-justified automatically.
// RULE_15: Half-duplex format transmits only the low eight bits of each word.
// RULE_16: Half-duplex receive length follows the programmed data size.
// RULE_17: Disabling the port leaves both FIFOs intact, allowing transmit preload.
// RULE_18: Software leaves control bits 31:4 alone; device reads them as zero.

module ssc_fifo #(
	parameter int unsigned W = 16,
	parameter int unsigned DEPTH = 8
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} ssc_fifo_type;

	ssc_fifo_type f_r;
	ssc_fifo_type f_nxt;
	logic push;
	logic pop;

	always_comb begin
		f_nxt = f_r;
		in_ready = (f_r.cnt != (AW+1)'(DEPTH));
		out_valid = (f_r.cnt != '0);
		out_data = f_r.mem[f_r.rp];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push) begin
			f_nxt.mem[f_r.wp] = in_data;
			f_nxt.wp = (f_r.wp == AW'(DEPTH - 1)) ? '0 : f_r.wp + 1'b1;
		end
		if (pop) begin
			f_nxt.rp = (f_r.rp == AW'(DEPTH - 1)) ? '0 : f_r.rp + 1'b1;
		end
		f_nxt.cnt = f_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			f_r <= '0;
		end else begin
			f_r <= f_nxt;
		end
	end
endmodule : ssc_fifo

module ssc_port import ssc_pkg::*; #(
	parameter int unsigned TX_DEPTH = 8,
	parameter int unsigned RX_DEPTH = 8
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [SSC_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic serial_tx_pin,
	output logic serial_tx_oe,
	input wire logic serial_rx_pin,
	output logic sclk_out,
	output logic sclk_oe,
	input wire logic sclk_in,
	output logic frame_out_n,
	output logic frame_oe,
	input wire logic frame_in_n
);
	typedef struct packed {
		ssc_ctrl_type ctrl;
		ssc_cfg_type cfg;
		ssc_state_type st;
		logic ack;
		logic rd_pop;
		logic [31:0] rdata;
		logic [7:0] div;
		logic sclk;
		logic frame;
		logic overrun;
		logic [4:0] bits;
		logic [SSC_DW-1:0] tx_sh;
		logic [SSC_DW-1:0] rx_sh;
		logic [1:0] sclk_s;
		logic [1:0] fss_s;
		logic [1:0] rxd_s;
		logic sclk_d;
		logic fss_d;
	} ssc_core_type;

	ssc_core_type s_r;
	ssc_core_type s_nxt;

	logic tx_push;
	logic tx_in_ready;
	logic tx_out_valid;
	logic [SSC_DW-1:0] tx_out_data;
	logic tx_pop;
	logic rx_push;
	logic [SSC_DW-1:0] rx_word;
	logic skid_ready;
	logic skid_valid;
	logic [SSC_DW-1:0] skid_data;
	logic rx_in_ready;
	logic rx_out_valid;
	logic [SSC_DW-1:0] rx_out_data;
	logic rx_pop;
	logic [4:0] n_bits;
	logic [4:0] tx_len;
	logic [4:0] rx_start;
	logic [4:0] total;
	logic half;
	logic rx_in;
	logic sample_ev;
	logic shift_ev;
	logic rx_cap;
	logic start;
	logic acc;
	logic hold;
	logic done;
	ssc_stat_type stat;

	function automatic logic [4:0] ssc_size(input logic [3:0] dss);
		ssc_size = (dss < SSC_DSS_MIN) ? SSC_MIN_BITS : 5'({1'b0, dss} + 5'h01);
	endfunction : ssc_size

	function automatic logic [SSC_DW-1:0] ssc_mask(input logic [4:0] n);
		ssc_mask = SSC_ALL_ONES >> (SSC_FULL_BITS - n);
	endfunction : ssc_mask

	ssc_fifo #(.W(SSC_DW), .DEPTH(TX_DEPTH)) u_tx_fifo (
		.mclk(mclk),
		.reset(reset),
		.in_valid(tx_push),
		.in_ready(tx_in_ready),
		.in_data(avs_writedata[SSC_DW-1:0]),
		.out_valid(tx_out_valid),
		.out_ready(tx_pop),
		.out_data(tx_out_data)
	);

	// Two-entry skid absorbs a word while the receive FIFO is briefly full
	ssc_fifo #(.W(SSC_DW), .DEPTH(2)) u_rx_skid (
		.mclk(mclk),
		.reset(reset),
		.in_valid(rx_push),
		.in_ready(skid_ready),
		.in_data(rx_word),
		.out_valid(skid_valid),
		.out_ready(rx_in_ready),
		.out_data(skid_data)
	);

	ssc_fifo #(.W(SSC_DW), .DEPTH(RX_DEPTH)) u_rx_fifo (
		.mclk(mclk),
		.reset(reset),
		.in_valid(skid_valid),
		.in_ready(rx_in_ready),
		.in_data(skid_data),
		.out_valid(rx_out_valid),
		.out_ready(rx_pop),
		.out_data(rx_out_data)
	);

	always_comb begin
		s_nxt = s_r;
		n_bits = ssc_size(s_r.cfg.dss);
		half = (s_r.cfg.frf == SSC_FRF_HALF);
		tx_len = half ? SSC_HALF_TX_BITS : n_bits; // [RULE_15]
		rx_start = half ? SSC_HALF_TX_BITS : '0;
		total = half ? 5'(SSC_HALF_TX_BITS + n_bits) : n_bits; // [RULE_16]
		rx_in = s_r.ctrl.loopback_enable ? s_r.tx_sh[SSC_DW-1] : s_r.rxd_s[1]; // [RULE_07]
		rx_word = s_r.rx_sh & ssc_mask(n_bits); // [RULE_14]
		sample_ev = 1'b0;
		shift_ev = 1'b0;
		rx_cap = 1'b0;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		start = 1'b0;
		stat.overrun = s_r.overrun;
		stat.busy = (s_r.st != SSC_ST_IDLE) || tx_out_valid;
		stat.rx_full = !rx_in_ready;
		stat.rx_not_empty = rx_out_valid;
		stat.tx_not_full = tx_in_ready;
		stat.tx_empty = !tx_out_valid;

		// Pin synchronisers
		s_nxt.sclk_s = {s_r.sclk_s[0], sclk_in};
		s_nxt.fss_s = {s_r.fss_s[0], frame_in_n};
		s_nxt.rxd_s = {s_r.rxd_s[0], serial_rx_pin};
		s_nxt.sclk_d = s_r.sclk_s[1];
		s_nxt.fss_d = s_r.fss_s[1];

		// Bus slave: one wait cycle, longer for a data write while the transmit FIFO is full
		avs_waitrequest = (avs_read || avs_write) && !s_r.ack;
		acc = (avs_read || avs_write) && !s_r.ack;
		hold = avs_write && (avs_address == SSC_OFS_DATA) && !tx_in_ready;
		done = (avs_read || avs_write) && s_r.ack;
		s_nxt.ack = acc && !hold;
		if (acc) begin
			s_nxt.rdata = '0;
			s_nxt.rd_pop = 1'b0;
			case (avs_address)
				SSC_OFS_CTRL0: begin
					s_nxt.rdata[SSC_DW-1:0] = s_r.cfg;
				end
				SSC_OFS_CTRL1: begin
					s_nxt.rdata[3:0] = s_r.ctrl; // [RULE_18]
				end
				SSC_OFS_DATA: begin
					s_nxt.rdata[SSC_DW-1:0] = rx_out_valid ? rx_out_data : '0; // [RULE_08]
					s_nxt.rd_pop = avs_read && rx_out_valid;
				end
				SSC_OFS_STAT: begin
					s_nxt.rdata[5:0] = stat;
				end
				default: begin
				end
			endcase
		end
		tx_push = done && avs_write && (avs_address == SSC_OFS_DATA); // [RULE_10]
		rx_pop = done && avs_read && s_r.rd_pop; // [RULE_09]
		if (done && avs_read && (avs_address == SSC_OFS_STAT)) begin
			s_nxt.overrun = 1'b0;
		end
		if (done && avs_write && avs_byteenable[0]) begin
			if (avs_address == SSC_OFS_CTRL1) begin
				s_nxt.ctrl.port_enable = avs_writedata[1];
				s_nxt.ctrl.loopback_enable = avs_writedata[0];
				s_nxt.ctrl.slave_output_disable = avs_writedata[3];
				// Role change mid-frame would corrupt the shift engine
				if (!s_r.ctrl.port_enable) begin
					s_nxt.ctrl.master_slave_select = avs_writedata[2]; // [RULE_03]
				end
			end
			if (avs_address == SSC_OFS_CTRL0 && !s_r.ctrl.port_enable) begin // [RULE_06]
				s_nxt.cfg.dss = avs_writedata[3:0];
				s_nxt.cfg.frf = ssc_frf_type'(avs_writedata[5:4]);
			end
		end
		if (done && avs_write && avs_byteenable[1] && avs_address == SSC_OFS_CTRL0
				&& !s_r.ctrl.port_enable) begin
			s_nxt.cfg.scr = avs_writedata[15:8];
		end

		// Edge events: slave follows the pin clock, master its own divider
		if (s_r.ctrl.master_slave_select) begin // [RULE_04]
			sample_ev = s_r.sclk_s[1] && !s_r.sclk_d;
			shift_ev = !s_r.sclk_s[1] && s_r.sclk_d;
		end else if (s_r.div == '0) begin
			sample_ev = !s_r.sclk;
			shift_ev = s_r.sclk;
		end

		case (s_r.st)
			SSC_ST_IDLE: begin
				s_nxt.frame = 1'b0;
				s_nxt.sclk = 1'b0;
				s_nxt.bits = '0;
				s_nxt.div = s_r.cfg.scr;
				start = s_r.ctrl.master_slave_select ? (s_r.fss_d && !s_r.fss_s[1])
					: tx_out_valid;
				if (s_r.ctrl.port_enable && start) begin // [RULE_05]
					tx_pop = tx_out_valid; // [RULE_12]
					s_nxt.tx_sh = tx_out_valid ? SSC_DW'((tx_out_data & ssc_mask(tx_len))
						<< (SSC_FULL_BITS - tx_len)) : '0; // [RULE_13]
					s_nxt.st = SSC_ST_SHIFT;
					s_nxt.frame = !s_r.ctrl.master_slave_select;
				end
			end
			SSC_ST_SHIFT: begin
				if (!s_r.ctrl.master_slave_select) begin
					s_nxt.div = (s_r.div == '0) ? s_r.cfg.scr : s_r.div - 1'b1;
				end
				if (sample_ev && s_r.bits != total) begin
					s_nxt.sclk = !s_r.ctrl.master_slave_select;
					s_nxt.bits = s_r.bits + 1'b1;
					if (s_r.bits >= rx_start) begin
						rx_cap = 1'b1;
						s_nxt.rx_sh = {s_r.rx_sh[SSC_DW-2:0], rx_in}; // [RULE_11]
					end
				end else if (shift_ev) begin
					s_nxt.sclk = 1'b0;
					s_nxt.tx_sh = {s_r.tx_sh[SSC_DW-2:0], 1'b0};
				end
				// Slave ends on the last sample, master after the trailing clock fall
				if (s_r.bits == total && (s_r.ctrl.master_slave_select || shift_ev)) begin
					s_nxt.st = SSC_ST_DONE;
				end else if (s_r.ctrl.master_slave_select && s_r.fss_s[1]) begin
					s_nxt.st = SSC_ST_IDLE;
				end
			end
			SSC_ST_DONE: begin
				rx_push = 1'b1; // [RULE_11]
				if (!skid_ready) begin
					s_nxt.overrun = 1'b1;
				end
				s_nxt.st = SSC_ST_IDLE;
				s_nxt.frame = 1'b0;
				s_nxt.tx_sh = '0;
			end
			default: begin
				s_nxt.st = SSC_ST_IDLE;
			end
		endcase

		// Abort only the frame; FIFO contents survive a disable
		if (!s_r.ctrl.port_enable) begin // [RULE_05] [RULE_17]
			s_nxt.st = SSC_ST_IDLE;
			s_nxt.frame = 1'b0;
			s_nxt.sclk = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			s_r <= '0;
			s_r.ctrl <= SSC_CTRL_RST;
			s_r.cfg <= SSC_CFG_RST;
			s_r.st <= SSC_ST_IDLE;
			s_r.sclk_s <= 2'h0;
			s_r.fss_s <= '1;
			s_r.fss_d <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign avs_readdata = s_r.rdata;
	assign serial_tx_pin = s_r.tx_sh[SSC_DW-1];
	// Shared slave data line: a disabled slave must stay off it
	assign serial_tx_oe = s_r.ctrl.port_enable && (s_r.ctrl.master_slave_select
		? (!s_r.ctrl.slave_output_disable && s_r.st != SSC_ST_IDLE) : 1'b1); // [RULE_01] [RULE_02]
	assign sclk_out = s_r.sclk;
	assign sclk_oe = s_r.ctrl.port_enable && !s_r.ctrl.master_slave_select; // [RULE_04]
	assign frame_out_n = !s_r.frame;
	assign frame_oe = s_r.ctrl.port_enable && !s_r.ctrl.master_slave_select;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	a_sod_quiet: assert property ((s_r.ctrl.master_slave_select && s_r.ctrl.slave_output_disable)
		|-> !serial_tx_oe) else $error("Slave drove tx while disabled"); // [RULE_01]
	a_master_drives: assert property ((s_r.ctrl.port_enable && !s_r.ctrl.master_slave_select)
		|-> serial_tx_oe) else $error("Master not driving tx"); // [RULE_02]
	a_role_locked: assert property ($past(s_r.ctrl.port_enable) |->
		$stable(s_r.ctrl.master_slave_select)) else $error("Role changed while enabled"); // [RULE_03]
	a_slave_no_clock: assert property (s_r.ctrl.master_slave_select |-> !sclk_oe && !frame_oe)
		else $error("Slave drives clock or frame"); // [RULE_04]
	a_disabled_idle: assert property (!s_r.ctrl.port_enable |-> !tx_pop ##1 s_r.st == SSC_ST_IDLE)
		else $error("Transfer while disabled"); // [RULE_05]
	a_loop_capture: assert property ((rx_cap && s_r.ctrl.loopback_enable) |=>
		s_r.rx_sh[0] == $past(s_r.tx_sh[SSC_DW-1])) else $error("Loopback bit mismatch"); // [RULE_07]
	a_data_upper: assert property ((avs_read && !avs_waitrequest && avs_address == SSC_OFS_DATA)
		|-> avs_readdata[31:16] == 16'h0000) else $error("Data upper bits set"); // [RULE_08]
	a_write_stored: assert property ((avs_write && !avs_waitrequest && avs_address == SSC_OFS_DATA)
		|=> tx_out_valid) else $error("Written word not in tx FIFO"); // [RULE_10]
	a_rx_justified: assert property (rx_push |-> (rx_word & ~ssc_mask(n_bits)) == '0)
		else $error("Received word not right-justified"); // [RULE_14]
	a_half_tx: assert property ((tx_pop && half) |=> s_r.tx_sh[7:0] == '0)
		else $error("Half-duplex sent more than a byte"); // [RULE_15]
	a_fifo_kept: assert property ((!s_r.ctrl.port_enable && tx_out_valid) |=> tx_out_valid)
		else $error("Tx FIFO lost on disable"); // [RULE_17]

	c_master_frame: cover property (!s_r.ctrl.master_slave_select && rx_push);
	c_slave_frame: cover property (s_r.ctrl.master_slave_select && rx_push);
	c_half_frame: cover property (half && rx_push);
	c_loop_frame: cover property (s_r.ctrl.loopback_enable && rx_push);
endmodule : ssc_port

// ==== shared/ssc_pkg.sv ====
// Constants, types and register map of the serial port control and data block
package ssc_pkg;

	localparam int unsigned SSC_DW = 16;
	localparam int unsigned SSC_AW = 8;

	localparam logic [SSC_AW-1:0] SSC_OFS_CTRL0 = 8'h00;
	localparam logic [SSC_AW-1:0] SSC_OFS_CTRL1 = 8'h04;
	localparam logic [SSC_AW-1:0] SSC_OFS_DATA = 8'h08;
	localparam logic [SSC_AW-1:0] SSC_OFS_STAT = 8'h0c;

	localparam logic [3:0] SSC_DSS_MIN = 4'h3;
	localparam logic [4:0] SSC_MIN_BITS = 5'h04;
	localparam logic [4:0] SSC_HALF_TX_BITS = 5'h08;
	localparam logic [4:0] SSC_FULL_BITS = 5'h10;
	localparam logic [15:0] SSC_ALL_ONES = 16'hffff;

	typedef enum logic [1:0] {
		SSC_FRF_SPI = 2'h0,
		SSC_FRF_SYNC = 2'h1,
		SSC_FRF_HALF = 2'h2,
		SSC_FRF_RSV = 2'h3
	} ssc_frf_type;

	typedef enum logic [2:0] {
		SSC_ST_IDLE = 3'b001,
		SSC_ST_SHIFT = 3'b010,
		SSC_ST_DONE = 3'b100
	} ssc_state_type;

	// Control one layout, bit 3 down to bit 0
	typedef struct packed {
		logic slave_output_disable;
		logic master_slave_select;
		logic port_enable;
		logic loopback_enable;
	} ssc_ctrl_type;

	localparam ssc_ctrl_type SSC_CTRL_RST = 4'h0;

	// Control zero layout, bits 15:0
	typedef struct packed {
		logic [7:0] scr;
		logic [1:0] rsv;
		ssc_frf_type frf;
		logic [3:0] dss;
	} ssc_cfg_type;

	localparam ssc_cfg_type SSC_CFG_RST = 16'h0000;

	// Status layout, bits 5:0
	typedef struct packed {
		logic overrun;
		logic busy;
		logic rx_full;
		logic rx_not_empty;
		logic tx_not_full;
		logic tx_empty;
	} ssc_stat_type;

endpackage : ssc_pkg

// ==== verification/ssc_partner.sv ====
// Behavioural far-end serial device answering a master-mode port
module ssc_partner (
	input wire logic mclk,
	input wire logic sclk,
	input wire logic frame_n,
	input wire logic data_in,
	output logic data_out,
	input wire logic [15:0] reply,
	output logic [15:0] captured,
	output logic [4:0] n_bits
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] n_fall_r;
	logic idle_r;

	initial begin
		n_fall_r = 4'h0;
		idle_r = 1'b0;
		captured = 16'h0;
		n_bits = 5'h0;
	end

	// No pull resistor on this line, so idle shows a toggling pattern
	always @(posedge mclk) begin
		idle_r <= ~idle_r;
	end

	// Next bit presented after each falling serial clock edge, MSB first
	always @(negedge sclk or posedge frame_n) begin
		if (frame_n) begin
			n_fall_r <= 4'h0;
		end else begin
			n_fall_r <= n_fall_r + 4'h1;
		end
	end

	assign data_out = frame_n ? idle_r : reply[4'hf - n_fall_r];

	// Clock is idle low at frame start, high at a sampling edge
	always @(posedge sclk or negedge frame_n) begin
		if (!sclk) begin
			captured <= 16'h0;
			n_bits <= 5'h0;
		end else begin
			captured <= {captured[14:0], data_in};
			n_bits <= n_bits + 5'h1;
		end
	end
endmodule : ssc_partner

// ==== verification/tb.sv ====
// Self-checking bench for the serial port control and data block
module tb import ssc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	logic mclk, reset, avs_read, avs_write, serial_tx_pin, serial_tx_oe, serial_rx_pin;
	logic sclk_out, sclk_oe, frame_out_n, frame_oe, avs_waitrequest;
	logic sclk_in, frame_in_n;
	logic [SSC_AW-1:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [15:0] reply, captured;
	logic [4:0] n_bits;
	int n_fail, n_compared, cycles;

	ssc_port #(.TX_DEPTH(8), .RX_DEPTH(8)) dut (.mclk(mclk), .reset(reset),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .serial_tx_pin(serial_tx_pin),
		.serial_tx_oe(serial_tx_oe), .serial_rx_pin(serial_rx_pin), .sclk_out(sclk_out),
		.sclk_oe(sclk_oe), .sclk_in(sclk_in), .frame_out_n(frame_out_n), .frame_oe(frame_oe),
		.frame_in_n(frame_in_n));

	ssc_partner u_partner (.mclk(mclk), .sclk(sclk_out), .frame_n(frame_out_n),
		.data_in(serial_tx_pin), .data_out(serial_rx_pin), .reply(reply),
		.captured(captured), .n_bits(n_bits));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			finish_test();
		end
	end

	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		do begin
			@(posedge mclk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	// External master for slave mode; half period of 4 clocks covers the pin synchronisers
	task automatic ext_frame(input logic exp_oe);
		@(posedge mclk);
		frame_in_n <= 1'b0;
		repeat (4) begin
			repeat (4) @(posedge mclk);
			sclk_in <= 1'b1;
			chk({31'h0, serial_tx_oe}, {31'h0, exp_oe});
			repeat (4) @(posedge mclk);
			sclk_in <= 1'b0;
		end
		repeat (4) @(posedge mclk);
		frame_in_n <= 1'b1;
	endtask : ext_frame

	task automatic wait_rx;
		repeat (100) begin
			bus(1'b0, SSC_OFS_STAT, 32'h0);
			if (q[4] === 1'b0 && q[2] === 1'b1) break;
		end
	endtask : wait_rx

	task automatic t_reset;
		bus(1'b0, SSC_OFS_CTRL1, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, SSC_OFS_DATA, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, SSC_OFS_CTRL1, 32'hffff_fff0);
		bus(1'b0, SSC_OFS_CTRL1, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, serial_tx_oe}, 32'h0);
	endtask : t_reset

	task automatic t_loop;
		bus(1'b1, SSC_OFS_CTRL0, 32'h0007);
		bus(1'b1, SSC_OFS_DATA, 32'hffff_01a5);
		bus(1'b0, SSC_OFS_STAT, 32'h0);
		chk({30'h0, q[1:0]}, 32'h2);
		chk({30'h0, sclk_oe, frame_out_n}, 32'h1);
		bus(1'b1, SSC_OFS_CTRL1, 32'h3);
		wait_rx();
		bus(1'b0, SSC_OFS_DATA, 32'h0);
		chk(q, 32'h0000_00a5);
		bus(1'b0, SSC_OFS_DATA, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, SSC_OFS_CTRL1, 32'h0);
	endtask : t_loop

	task automatic t_master;
		reply = 16'ha000;
		// Three clocks per half bit, so synced return data has settled at sampling
		bus(1'b1, SSC_OFS_CTRL0, 32'h0203);
		bus(1'b1, SSC_OFS_DATA, 32'h0000_fff6);
		bus(1'b1, SSC_OFS_CTRL1, 32'ha);
		@(negedge mclk);
		chk({31'h0, serial_tx_oe}, 32'h1);
		wait_rx();
		bus(1'b0, SSC_OFS_DATA, 32'h0);
		chk(q, 32'h0000_000a);
		chk({16'h0, captured}, 32'h6);
		chk({27'h0, n_bits}, 32'h4);
		bus(1'b1, SSC_OFS_CTRL1, 32'h0);
	endtask : t_master

	task automatic t_half;
		reply = 16'h00a0;
		bus(1'b1, SSC_OFS_CTRL0, 32'h0223);
		bus(1'b1, SSC_OFS_DATA, 32'h0000_c35a);
		bus(1'b1, SSC_OFS_CTRL1, 32'h2);
		wait_rx();
		bus(1'b0, SSC_OFS_DATA, 32'h0);
		chk(q, 32'h0000_000a);
		chk({16'h0, captured}, 32'h05a0);
		chk({27'h0, n_bits}, 32'hc);
		bus(1'b1, SSC_OFS_CTRL1, 32'h0);
	endtask : t_half

	task automatic t_slave;
		bus(1'b1, SSC_OFS_CTRL0, 32'h0003);
		bus(1'b1, SSC_OFS_CTRL1, 32'hd);
		bus(1'b1, SSC_OFS_DATA, 32'h0009);
		bus(1'b1, SSC_OFS_CTRL1, 32'hf);
		chk({30'h0, sclk_oe, frame_oe}, 32'h0);
		ext_frame(1'b0);
		wait_rx();
		bus(1'b0, SSC_OFS_DATA, 32'h0);
		chk(q, 32'h0000_0009);
		// Select change while enabled must not stick
		bus(1'b1, SSC_OFS_CTRL1, 32'hb);
		bus(1'b0, SSC_OFS_CTRL1, 32'h0);
		chk(q, 32'hf);
		bus(1'b1, SSC_OFS_CTRL1, 32'h0);
		bus(1'b1, SSC_OFS_CTRL1, 32'h5);
		bus(1'b1, SSC_OFS_DATA, 32'h0006);
		bus(1'b1, SSC_OFS_CTRL1, 32'h7);
		ext_frame(1'b1);
		wait_rx();
		bus(1'b0, SSC_OFS_DATA, 32'h0);
		chk(q, 32'h0000_0006);
		bus(1'b1, SSC_OFS_CTRL1, 32'h0);
	endtask : t_slave

	initial begin
		reset = 1'b1;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		reply = 16'h0;
		sclk_in = 1'b0;
		frame_in_n = 1'b1;
		n_fail = 0;
		n_compared = 0;
		cycles = 0;
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		t_reset();
		t_loop();
		t_master();
		t_half();
		t_slave();
		finish_test();
	end
endmodule : tb
